// >>> verilog/pwm_pkg.sv
package pwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Waveform modes and output actions
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE  = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_FAST   = 2'h3;

  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] ACT_NONINV  = 2'h2;
  localparam logic [1:0] ACT_INV     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Counter limits and period lengths in ticks
  localparam logic [7:0] COUNT_MAX         = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM      = 8'h00;
  localparam int         FAST_PERIOD_TICKS = 256;
  localparam int         PHASE_PERIOD_TICKS = 510;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COMPARE = 8'h04;
  localparam logic [7:0] OFF_COUNT   = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_ACTIVE  = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_ACT_LSB  = 2;
  localparam int CTL_DIR_BIT  = 4;
  localparam int CTL_PORT_BIT = 5;
  localparam int STS_OVF_BIT  = 0;
  localparam int STS_CMP_BIT  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] MODE_RESET    = 2'h0;
  localparam logic [1:0] ACT_RESET     = 2'h0;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave states
  typedef enum logic [3:0] {
    BUS_IDLE    = 4'b0001,
    BUS_WRITE   = 4'b0010,
    BUS_RD_WAIT = 4'b0100,
    BUS_RD_DONE = 4'b1000
  } bus_state_t;

endpackage

// >>> verilog/pwm_counter.sv
`timescale 1ns/1ps
module pwm_counter
  import pwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic [1:0] mode,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  output logic      [7:0] count_reg,
  output logic            up_reg,
  output logic            overflow_event
);

  logic [7:0] count_next;
  logic       up_next;
  wire        is_max    = (count_reg == COUNT_MAX);
  wire        is_bottom = (count_reg == COUNT_BOTTOM);

  ////////////////////////////////////////////////////////////////////////////
  // Next count
  always_comb begin
    count_next = count_reg;
    up_next    = up_reg;
    if (load) begin
      count_next = load_value;
    end else if (tick) begin
      case (mode)
        MODE_FAST: begin
          count_next = is_max ? COUNT_BOTTOM : count_reg + 8'h01;
        end
        MODE_PHASE: begin
          if (up_reg) begin
            if (is_max) begin
              count_next = count_reg - 8'h01;
              up_next    = 1'b0;
            end else begin
              count_next = count_reg + 8'h01;
            end
          end else if (is_bottom) begin
            count_next = count_reg + 8'h01;
            up_next    = 1'b1;
          end else begin
            count_next = count_reg - 8'h01;
          end
        end
        default: begin
          count_next = count_reg;
        end
      endcase
    end
  end

  assign overflow_event = tick && !load &&
                          (((mode == MODE_FAST) && (count_next == COUNT_MAX) && !is_max) ||
                           ((mode == MODE_PHASE) && (count_next == COUNT_BOTTOM) && !is_bottom));

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= COUNT_RESET;
      up_reg    <= 1'b1;
    end else begin
      count_reg <= count_next;
      up_reg    <= up_next;
    end
  end

endmodule

// >>> verilog/pwm_waveform.sv
`timescale 1ns/1ps
module pwm_waveform
  import pwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic [1:0] mode,
  input  wire logic [1:0] action,
  input  wire logic [7:0] count,
  input  wire logic       up,
  input  wire logic [7:0] compare,
  output logic            level_reg
);

  // Level left by a match on the rising side (up) or falling side
  function automatic logic match_level(input logic [1:0] act, input logic up_side);
    match_level = up_side ? (act == ACT_INV) : (act != ACT_INV);
  endfunction

  wire  is_max    = (count == COUNT_MAX);
  wire  is_bottom = (count == COUNT_BOTTOM);
  wire  match     = (count == compare);
  wire  pwm_act   = action[1];
  logic level_next;

  always_comb begin
    level_next = level_reg;
    if (tick) begin
      case (mode)
        MODE_FAST: begin
          if (pwm_act && is_max) begin
            level_next = match_level(action, 1'b0);
          end else if (pwm_act && match) begin
            level_next = match_level(action, 1'b1);
          end else if ((action == ACT_TOGGLE) && match) begin
            level_next = ~level_reg;
          end
        end
        MODE_PHASE: begin
          if (pwm_act && is_max) begin
            level_next = match_level(action, compare != COUNT_MAX);
          end else if (pwm_act && match) begin
            level_next = match_level(action, up || is_bottom);
          end
        end
        default: begin
          level_next = level_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

endmodule

// >>> verilog/pwm_timer.sv
`timescale 1ns/1ps
module pwm_timer
  import pwm_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        TICK,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             PIN_OUT,
  output logic             PIN_OE,
  output logic             COMPARE_OUTPUT,
  output logic             OVERFLOW_FLAG,
  output logic             COMPARE_MATCH_FLAG
);

  import pwm_pkg::*;

  // Register selected by a latched byte address
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  bus_state_t state_reg;
  bus_state_t state_next;
  logic [7:0]  addr_reg;
  logic        addr_ok_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] read_mux;

  wire accept = HSEL && HREADY && HTRANS[1];
  wire addr_ok = (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
        if (accept) begin
          state_next = HWRITE ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          state_next = BUS_IDLE;
        end
      end
      BUS_RD_WAIT: begin
        state_next = BUS_RD_DONE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg <= BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      addr_reg    <= 8'h00;
      addr_ok_reg <= 1'b0;
    end else if (accept && (state_reg != BUS_RD_WAIT)) begin
      addr_reg    <= HADDR[7:0];
      addr_ok_reg <= addr_ok;
    end
  end

  assign HREADYOUT = (state_reg != BUS_RD_WAIT);
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_phase  = (state_reg == BUS_WRITE) && addr_ok_reg;
  wire wr_ctl    = wr_phase && reg_hit(addr_reg, OFF_CONTROL);
  wire wr_cmp    = wr_phase && reg_hit(addr_reg, OFF_COMPARE);
  wire wr_cnt    = wr_phase && reg_hit(addr_reg, OFF_COUNT);
  wire wr_sts    = wr_phase && reg_hit(addr_reg, OFF_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  logic [1:0] mode_reg;
  logic [1:0] action_reg;
  logic       pin_dir_reg;
  logic       port_data_reg;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mode_reg      <= MODE_RESET;
      action_reg    <= ACT_RESET;
      pin_dir_reg   <= 1'b0;
      port_data_reg <= 1'b0;
    end else if (wr_ctl) begin
      mode_reg      <= HWDATA[CTL_MODE_LSB +: 2];
      action_reg    <= HWDATA[CTL_ACT_LSB +: 2];
      pin_dir_reg   <= HWDATA[CTL_DIR_BIT];
      port_data_reg <= HWDATA[CTL_PORT_BIT];
    end
  end

  wire pwm_mode = (mode_reg == MODE_FAST) || (mode_reg == MODE_PHASE);

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  logic [7:0] count_value;
  logic       count_up;
  logic       overflow_event;

  pwm_counter u_counter (
    .clk            (CLOCK),
    .rst            (RST),
    .tick           (TICK),
    .mode           (mode_reg),
    .load           (wr_cnt),
    .load_value     (HWDATA[7:0]),
    .count_reg      (count_value),
    .up_reg         (count_up),
    .overflow_event (overflow_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare value, double buffered in PWM modes
  logic [7:0] compare_buffer_reg;
  logic [7:0] compare_active_reg;

  wire        load_now    = TICK && pwm_mode && (count_value == COUNT_MAX);
  wire  [7:0] compare_eff = load_now ? compare_buffer_reg : compare_active_reg;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      compare_buffer_reg <= COMPARE_RESET;
    end else if (wr_cmp) begin
      compare_buffer_reg <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      compare_active_reg <= COMPARE_RESET;
    end else if (!pwm_mode || load_now) begin
      compare_active_reg <= compare_buffer_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generation
  logic compare_level;

  pwm_waveform u_waveform (
    .clk       (CLOCK),
    .rst       (RST),
    .tick      (TICK),
    .mode      (mode_reg),
    .action    (action_reg),
    .count     (count_value),
    .up        (count_up),
    .compare   (compare_eff),
    .level_reg (compare_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, set wins over clear
  logic overflow_flag_reg;
  logic compare_match_flag_reg;

  wire match_event = TICK && pwm_mode && !wr_cnt && (count_value == compare_eff);
  wire clr_ovf     = wr_sts && HWDATA[STS_OVF_BIT];
  wire clr_cmp     = wr_sts && HWDATA[STS_CMP_BIT];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      overflow_flag_reg      <= 1'b0;
      compare_match_flag_reg <= 1'b0;
    end else begin
      overflow_flag_reg      <= overflow_event || (overflow_flag_reg && !clr_ovf);
      compare_match_flag_reg <= match_event || (compare_match_flag_reg && !clr_cmp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  logic pin_out_reg;
  logic pin_oe_reg;

  wire override = |action_reg;
  wire pin_next = override ? compare_level : port_data_reg;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg  <= 1'b0;
    end else begin
      pin_out_reg <= pin_next && pin_dir_reg;
      pin_oe_reg  <= pin_dir_reg;
    end
  end

  assign PIN_OUT            = pin_out_reg;
  assign PIN_OE             = pin_oe_reg;
  assign COMPARE_OUTPUT     = compare_level;
  assign OVERFLOW_FLAG      = overflow_flag_reg;
  assign COMPARE_MATCH_FLAG = compare_match_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    read_mux = 32'h00000000;
    if (addr_ok_reg) begin
      case (addr_reg)
        OFF_CONTROL: begin
          read_mux[CTL_MODE_LSB +: 2] = mode_reg;
          read_mux[CTL_ACT_LSB +: 2]  = action_reg;
          read_mux[CTL_DIR_BIT]       = pin_dir_reg;
          read_mux[CTL_PORT_BIT]      = port_data_reg;
        end
        OFF_COMPARE: begin
          read_mux[7:0] = compare_buffer_reg;
        end
        OFF_COUNT: begin
          read_mux[7:0] = count_value;
        end
        OFF_STATUS: begin
          read_mux[STS_OVF_BIT] = overflow_flag_reg;
          read_mux[STS_CMP_BIT] = compare_match_flag_reg;
        end
        OFF_ACTIVE: begin
          read_mux[7:0] = compare_active_reg;
        end
        default: begin
          read_mux = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hrdata_reg <= 32'h00000000;
    end else if (state_reg == BUS_RD_WAIT) begin
      hrdata_reg <= read_mux;
    end
  end

endmodule

// >>> dv/pwm_load.sv
`timescale 1ns/1ps
module pwm_load (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic      [15:0] high_cnt
);
  // Pull-down holds the line low while the pin is not driven
  wire level = pin_oe ? pin_out : 1'b0;
  always_ff @(posedge clk) begin
    if (clr) begin
      high_cnt <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + {15'h0000, level};
    end
  end
endmodule

// >>> dv/pwm_timer_asserts.sv
`timescale 1ns/1ps
module pwm_timer_asserts
  import pwm_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        TICK,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        PIN_OUT,
  input wire logic        PIN_OE,
  input wire logic        COMPARE_OUTPUT,
  input wire logic        OVERFLOW_FLAG,
  input wire logic        COMPARE_MATCH_FLAG
);
  wire  acc = HSEL && HREADY && HTRANS[1];
  logic sts_wr_reg;
  wire  ovf_clr = sts_wr_reg && HWDATA[STS_OVF_BIT];
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sts_wr_reg <= 1'b0;
    end else begin
      sts_wr_reg <= acc && HWRITE && (HADDR[7:0] == OFF_STATUS);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  AST_RESP_OKAY: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  AST_READ_WAIT: assert property (acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (acc && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  AST_PIN_OFF: assert property (!PIN_OE |-> !PIN_OUT)
    else $error("pin driven while disabled");
  AST_OUT_ON_TICK: assert property ($changed(COMPARE_OUTPUT) |-> $past(TICK))
    else $error("output changed without tick");
  AST_OVF_ON_TICK: assert property ($rose(OVERFLOW_FLAG) |-> $past(TICK))
    else $error("overflow set without tick");
  AST_MATCH_ON_TICK: assert property ($rose(COMPARE_MATCH_FLAG) |-> $past(TICK))
    else $error("match set without tick");
  AST_FLAG_CLEAR: assert property ($fell(OVERFLOW_FLAG) |-> $past(ovf_clr))
    else $error("overflow cleared without write");
  cover property (acc && !HWRITE);
  cover property ($rose(OVERFLOW_FLAG));
  cover property ($fell(OVERFLOW_FLAG));
endmodule

bind pwm_timer pwm_timer_asserts chk_u (.CLOCK, .RST, .TICK, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
  .HREADY, .HREADYOUT, .HRESP, .PIN_OUT, .PIN_OE, .COMPARE_OUTPUT, .OVERFLOW_FLAG, .COMPARE_MATCH_FLAG);

// >>> dv/pwm_timer_tb_top.sv
`timescale 1ns/1ps
module pwm_timer_tb_top;
  import pwm_pkg::*;
  logic        CLOCK, RST, TICK, HSEL, HWRITE, HREADYOUT, HRESP;
  logic        PIN_OUT, PIN_OE, COMPARE_OUTPUT, OVERFLOW_FLAG, COMPARE_MATCH_FLAG;
  logic [31:0] HADDR, HWDATA, HRDATA, prb_val;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] exp_q[$];
  logic [15:0] high_cnt;
  logic        ld_clr, prb_en, rd_pend, lv;
  int          errors, checks_done, seed, c, per, i, h;
  logic [1:0]  tm[10] = '{MODE_FAST, MODE_FAST, MODE_FAST, MODE_FAST, MODE_FAST,
                          MODE_PHASE, MODE_PHASE, MODE_PHASE, MODE_PHASE, MODE_PHASE};
  logic [1:0]  ta[10] = '{ACT_NONINV, ACT_NONINV, ACT_INV, ACT_TOGGLE, ACT_NONE,
                          ACT_NONINV, ACT_NONINV, ACT_INV, ACT_NONINV, ACT_INV};
  int          tc[10] = '{0, 255, -1, -1, -1, 0, 255, -1, -1, 255};

  pwm_timer dut_u (.CLOCK, .RST, .TICK, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .PIN_OUT, .PIN_OE, .COMPARE_OUTPUT,
    .OVERFLOW_FLAG, .COMPARE_MATCH_FLAG);
  pwm_load load_u (.clk(CLOCK), .clr(ld_clr), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .high_cnt(high_cnt));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    checks_done++;
    if (got !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // Monitor: read completions and load probes
  always @(posedge CLOCK) begin
    if (rd_pend && HREADYOUT) chk(HRDATA);
    if (prb_en) chk(prb_val);
    if (RST) rd_pend <= 1'b0;
    else if (HREADYOUT) rd_pend <= HSEL && HTRANS[1] && !HWRITE;
  end

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h000000, a};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    if (w) HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask

  // Probe a sampled value against an expectation, two edges apart from the next probe
  task prb(input logic [31:0] v, input logic [31:0] e);
    exp_q.push_back(e);
    prb_val <= v;
    prb_en <= 1'b1;
    @(posedge CLOCK);
    prb_en <= 1'b0;
    @(posedge CLOCK);
  endtask

  task meas(input int w, input int e);
    ld_clr <= 1'b1;
    @(posedge CLOCK);
    ld_clr <= 1'b0;
    repeat (w + 1) @(posedge CLOCK);
    prb({16'h0000, high_cnt}, 32'(e));
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] a, input logic d);
    return 32'(m) | (32'(a) << CTL_ACT_LSB) | (32'(d) << CTL_DIR_BIT) | (32'h1 << CTL_PORT_BIT);
  endfunction

  // High cycles of the load in one period
  function automatic int hi(input logic [1:0] m, input logic [1:0] a, input int k);
    int p;
    p = (m == MODE_FAST) ? FAST_PERIOD_TICKS : PHASE_PERIOD_TICKS;
    if (a == ACT_NONE) return p;
    if (m == MODE_FAST) begin
      if (a == ACT_TOGGLE) return p / 2;
      return (a == ACT_NONINV) ? k + 1 : p - k - 1;
    end
    return (a == ACT_NONINV) ? 2 * k : p - 2 * k;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge CLOCK);
    errors++;
    end_of_test();
  end

  initial begin
    seed = $urandom(34);
    RST = 1'b1;
    TICK = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h00000000;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h00000000;
    ld_clr = 1'b0;
    prb_en = 1'b0;
    prb_val = 32'h00000000;
    rd_pend = 1'b0;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    TICK <= 1'b1;
    @(posedge CLOCK);
    wr(8'h14, 32'hFFFFFFFF);
    for (i = 0; i < 6; i++) rd(8'(i * 4), 32'h00000000);
    for (i = 0; i < 10; i++) begin
      c = (tc[i] < 0) ? $urandom_range(254, 1) : tc[i];
      per = (tm[i] == MODE_FAST) ? FAST_PERIOD_TICKS : PHASE_PERIOD_TICKS;
      wr(OFF_COMPARE, 32'(c));
      wr(OFF_CONTROL, ctl(tm[i], ta[i], 1'b1));
      @(posedge CLOCK);
      lv = COMPARE_OUTPUT;
      repeat (1100) @(posedge CLOCK);
      meas(2 * per, 2 * hi(tm[i], ta[i], c));
      h = hi(tm[i], ta[i], c);
      if (ta[i] == ACT_NONE) prb({31'h00000000, COMPARE_OUTPUT}, {31'h00000000, lv});
      else if (h == 0 || h == per) prb({31'h00000000, COMPARE_OUTPUT}, 32'(h != 0));
    end
    for (i = 0; i < 2; i++) begin
      wr(OFF_CONTROL, ctl(i ? MODE_FAST : MODE_PHASE, ACT_INV, 1'b1));
      TICK <= 1'b0;
      wr(OFF_STATUS, 32'h00000003);
      rd(OFF_STATUS, 32'h00000000);
      prb({30'h00000000, COMPARE_MATCH_FLAG, OVERFLOW_FLAG}, 32'h00000000);
      TICK <= 1'b1;
      repeat (520) @(posedge CLOCK);
      rd(OFF_STATUS, 32'h00000003);
      prb({30'h00000000, COMPARE_MATCH_FLAG, OVERFLOW_FLAG}, 32'h00000003);
    end
    TICK <= 1'b0;
    wr(OFF_COMPARE, 32'h00000040);
    wr(OFF_ACTIVE, 32'h00000077);
    rd(OFF_ACTIVE, 32'h000000FF);
    wr(OFF_COUNT, 32'h00000010);
    rd(OFF_COUNT, 32'h00000010);
    TICK <= 1'b1;
    repeat (300) @(posedge CLOCK);
    rd(OFF_ACTIVE, 32'h00000040);
    wr(OFF_CONTROL, ctl(MODE_FAST, ACT_NONINV, 1'b0));
    repeat (3) @(posedge CLOCK);
    meas(512, 0);
    repeat (3) @(posedge CLOCK);
    end_of_test();
  end
endmodule
